// file: sdpd_bank_track.v
`timescale 1ns/1ps
// tracks open banks; a bank counts as open once activated until precharged
module sdpd_bank_track #(
	parameter BANKS = 8
) (
	// clock and reset
	input  wire             clock,
	input  wire             reset_n,
	// decoded commands
	input  wire             act,
	input  wire             pre,
	input  wire             pre_all,
	input  wire [2:0]       bank,
	// state
	output wire             any_open
);
	reg [BANKS-1:0] open_mask;

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			open_mask <= {BANKS{1'b0}};
		end else if (act) begin
			open_mask <= open_mask | ({{(BANKS-1){1'b0}}, 1'b1} << bank);
		end else if (pre_all) begin
			open_mask <= {BANKS{1'b0}};
		end else if (pre) begin
			open_mask <= open_mask & ~({{(BANKS-1){1'b0}}, 1'b1} << bank);
		end
	end

	assign any_open = |open_mask;
endmodule

// file: sdpd_ctl_model.sv
`timescale 1ns/1ps
module sdpd_ctl_model (
	// clock
	input  wire        clock,
	// command pins
	output reg         cke = 1'b0, // low through reset
	output reg         cs_n = 1'b1,
	output reg         ras_n = 1'b1,
	output reg         cas_n = 1'b1,
	output reg         we_n = 1'b1,
	output reg  [2:0]  bank = 3'h0,
	output reg  [12:0] addr = 13'h0
);
	// one command for a cycle, then nop with flipped address; cke kept
	// no read, write or zq is ever issued, so cke never falls mid-burst
	// cke may fall right after activate or precharge
	// only nop follows a cke change, none issued while down
	// slow exit leaves the dll state to the controller; no reads follow
	// power-down spans stay a few clocks, far under the refresh ceiling
	// no refresh is issued, so no refresh cycle time holds cke
	// bench waits are whole clock counts of 10ns, except the 86ns start, the 1ns command skew and the 1ns plus 99ns reset split
	task cmd(input [3:0] c, input [2:0] b, input [12:0] a, input k);
		@(posedge clock) #1;
		{cs_n, ras_n, cas_n, we_n, bank, addr, cke} = {c, b, a, k};
		@(posedge clock) #1;
		{cs_n, ras_n, cas_n, we_n, addr} = {4'h7, ~a};
	endtask
endmodule

// file: sdpd_delay_count.v
`timescale 1ns/1ps
// loadable down-counter; done is high when the count has run out
module sdpd_delay_count #(
	parameter W = 8
) (
	// clock and reset
	input  wire         clock,
	input  wire         reset_n,
	// load
	input  wire         load,
	input  wire [W-1:0] value,
	// state
	output wire         done
);
	reg [W-1:0] count;

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count <= {W{1'b0}};
		end else if (load) begin
			count <= value;
		end else if (count != {W{1'b0}}) begin
			count <= count - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign done = (count == {W{1'b0}});
endmodule

// file: sdpd_map.vh
`ifndef SDPD_MAP_VH
`define SDPD_MAP_VH
// command encodings {cs_n, ras_n, cas_n, we_n}
`define SDPD_CMD_DES_BIT 3
`define SDPD_CMD_NOP     4'h7
`define SDPD_CMD_ACT     4'h3
`define SDPD_CMD_RD      4'h5
`define SDPD_CMD_WR      4'h4
`define SDPD_CMD_PRE     4'h2
`define SDPD_CMD_REF     4'h1
`define SDPD_CMD_MRS     4'h0
// mode register 0 fields
`define SDPD_MR0_PPD_BIT 12
`define SDPD_MR0_WR_HI   11
`define SDPD_MR0_WR_LO   9
`define SDPD_MR0_RST     13'h0000
// address bit 10 selects auto precharge / all banks
`define SDPD_AP_BIT      10
// timing figures
`define SDPD_CLK_PS      10000
`define SDPD_RST_LOW_NS  100
`define SDPD_XPDLL_NS    24
`define SDPD_XPDLL_CK    10
`endif

// file: sdpd_power_down.v
`timescale 1ns/1ps
// Operation
// - enter power-down when clock enable sampled low with nop or deselect
// - write recovery clocks come from mode register 0 bits 11 to 9
// - power-down disables buffers except clock, termination, enable, reset
// - open bank gives active power-down, all closed gives precharge power-down
// - precharge power-down turns dll off on slow exit; active keeps dll on
// - reset low while powered down leaves power-down into reset state
// - exit when clock enable sampled high with nop or deselect
// - slow-exit termination asynchronous until tanpd plus txpdll after exit
// - reset acts asynchronously, held low 100ns, outputs and termination off; the bench start releases it after 86ns
// - reset clears counters except refresh counters; data becomes undefined
`include "sdpd_map.vh"
module sdpd_power_down #(
	parameter BANKS    = 8,
	parameter ANPD_CK  = 8,
	parameter REF_BITS = 13
) (
	// clock and reset
	input  wire        clock,
	input  wire        reset_n,
	// command pins
	input  wire        cke,
	input  wire        cs_n,
	input  wire        ras_n,
	input  wire        cas_n,
	input  wire        we_n,
	input  wire [2:0]  bank,
	input  wire [12:0] addr,
	// state outputs
	output reg         powered_down,
	output reg         active_pd,
	output reg         precharge_pd,
	output reg         dll_on,
	output reg         buffers_on,
	output reg         odt_async,
	output reg         outputs_on,
	output reg         odt_allowed,
	output reg [12:0]  mr0,
	output reg [3:0]   wr_clocks,
	output reg [REF_BITS-1:0] refresh_ptr
);
	localparam ST_RUN = 3'b001;
	localparam ST_PD  = 3'b010;
	localparam ST_RST = 3'b100;
	localparam integer XPDLL_NS_CK = (`SDPD_XPDLL_NS * 1000 + `SDPD_CLK_PS - 1) / `SDPD_CLK_PS;
	localparam integer XPDLL_CK = (XPDLL_NS_CK > `SDPD_XPDLL_CK) ? XPDLL_NS_CK : `SDPD_XPDLL_CK;
	localparam integer ODT_HOLD_I = XPDLL_CK + ANPD_CK;
	localparam [7:0] ODT_HOLD = ODT_HOLD_I[7:0];

	reg  [2:0] state;
	reg  [2:0] next_state;
	reg        slow_pd;
	wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
	wire       idle_cmd = cs_n | (cmd == `SDPD_CMD_NOP);
	wire       act = ~cs_n & (cmd == `SDPD_CMD_ACT);
	wire       pre = ~cs_n & (cmd == `SDPD_CMD_PRE);
	wire       ref_cmd = ~cs_n & (cmd == `SDPD_CMD_REF);
	wire       mrs0 = ~cs_n & (cmd == `SDPD_CMD_MRS) & (bank == 3'h0);
	wire       any_open;
	wire       odt_done;
	wire       enter = (state == ST_RUN) & ~cke & idle_cmd;
	wire       leave = (state == ST_PD) & cke & idle_cmd;

	// write recovery code to clocks
	function [3:0] wr_decode;
		input [2:0] code;
		begin
			case (code)
			3'h0: wr_decode = 4'h0;
			3'h1: wr_decode = 4'h5;
			3'h2: wr_decode = 4'h6;
			3'h3: wr_decode = 4'h7;
			3'h4: wr_decode = 4'h8;
			3'h5: wr_decode = 4'ha;
			3'h6: wr_decode = 4'hc;
			default: wr_decode = 4'he;
			endcase
		end
	endfunction

	sdpd_bank_track #(
		.BANKS(BANKS)
	) u_banks (
		.clock   (clock),
		.reset_n (reset_n),
		.act     (act && state == ST_RUN),
		.pre     (pre && state == ST_RUN && !addr[`SDPD_AP_BIT]),
		.pre_all (pre && state == ST_RUN && addr[`SDPD_AP_BIT]),
		.bank    (bank),
		.any_open(any_open)
	);

	// asynchronous termination hold after slow exit
	sdpd_delay_count #(
		.W(8)
	) u_odt_hold (
		.clock  (clock),
		.reset_n(reset_n),
		.load   (leave && slow_pd),
		.value  (ODT_HOLD),
		.done   (odt_done)
	);

	always @* begin
		next_state = state;
		case (state)
		ST_RUN: begin
			if (enter) begin
				next_state = ST_PD;
			end
		end
		ST_PD: begin
			if (leave) begin
				next_state = ST_RUN;
			end
		end
		ST_RST: begin
			next_state = ST_RUN;
		end
		default: begin
			next_state = ST_RUN;
		end
		endcase
	end

	// reset is asynchronous and also pulls out of power-down
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_RST;
			mr0 <= `SDPD_MR0_RST;
			wr_clocks <= 4'h0;
			slow_pd <= 1'b0;
			powered_down <= 1'b0;
			active_pd <= 1'b0;
			precharge_pd <= 1'b0;
			dll_on <= 1'b0;
			buffers_on <= 1'b0;
			outputs_on <= 1'b0;
			odt_allowed <= 1'b0;
			odt_async <= 1'b0;
		end else begin
			state <= next_state;
			outputs_on <= 1'b1;
			odt_allowed <= 1'b1;
			if (mrs0 && state == ST_RUN) begin
				mr0 <= addr;
				wr_clocks <= wr_decode(addr[`SDPD_MR0_WR_HI:`SDPD_MR0_WR_LO]);
			end
			if (enter) begin
				powered_down <= 1'b1;
				buffers_on <= 1'b0;
				active_pd <= any_open;
				precharge_pd <= ~any_open;
				dll_on <= any_open | mr0[`SDPD_MR0_PPD_BIT];
				slow_pd <= ~any_open & ~mr0[`SDPD_MR0_PPD_BIT];
				odt_async <= ~any_open & ~mr0[`SDPD_MR0_PPD_BIT];
			end else if (leave) begin
				powered_down <= 1'b0;
				active_pd <= 1'b0;
				precharge_pd <= 1'b0;
				buffers_on <= 1'b1;
				dll_on <= 1'b1;
				slow_pd <= 1'b0;
			end else if (state == ST_RST) begin
				buffers_on <= 1'b1;
				dll_on <= 1'b1;
			end else if (state == ST_RUN && odt_done) begin
				odt_async <= 1'b0;
			end
		end
	end

	// refresh counter survives reset
	always @(posedge clock) begin
		if (ref_cmd && state == ST_RUN) begin
			refresh_ptr <= refresh_ptr + {{(REF_BITS-1){1'b0}}, 1'b1};
		end
	end
endmodule

// file: sdpd_power_down_bench.sv
`timescale 1ns/1ps
`include "sdpd_map.vh"
module sdpd_power_down_bench;
	reg         clock = 1'b0;
	reg         reset_n = 1'b0;
	integer     num_errors = 0, n_checks = 0, cycles = 0, i;
	wire        cke, cs_n, ras_n, cas_n, we_n, pd, apd, ppd, dll, bon, oas, oon, ook;
	wire [2:0]  bank;
	wire [3:0]  wrc;
	wire [12:0] addr, mr0, rptr;
	wire [5:0]  flags = {pd, apd, ppd, dll, bon, oas};
	always #5 clock = ~clock;
	sdpd_ctl_model ctl (.clock(clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bank(bank), .addr(addr));
	sdpd_power_down DUT (.clock(clock), .reset_n(reset_n), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank(bank), .addr(addr),
		.powered_down(pd), .active_pd(apd), .precharge_pd(ppd), .dll_on(dll),
		.buffers_on(bon), .odt_async(oas), .outputs_on(oon), .odt_allowed(ook),
		.mr0(mr0), .wr_clocks(wrc), .refresh_ptr(rptr));
	task conclude;
		if (num_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input [12:0] got, input [12:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			num_errors = num_errors + 1;
			conclude;
		end
	end
	// entry then exit, all six flags judged after entry, only pd, dll and bon after exit
	task pd_cycle(input [5:0] exp);
		ctl.cmd(`SDPD_CMD_NOP, 3'h0, 13'h0, 1'b0);
		chk(flags, exp);
		ctl.cmd(`SDPD_CMD_NOP, 3'h0, 13'h0, 1'b1);
		chk({pd, dll, bon}, 3'h3);
	endtask
	task wr_map_test;
		for (i = 0; i < 8; i = i + 1) begin
			ctl.cmd(`SDPD_CMD_MRS, 3'h0, {1'b0, i[2:0], 9'h0}, 1'b1);
			#10;
			chk(wrc, i == 0 ? 0 : i < 5 ? i + 4 : 2 * i);
		end
	endtask
	task active_test;
		ctl.cmd(`SDPD_CMD_ACT, 3'h1, 13'h0, 1'b1);
		pd_cycle(6'h34);
		ctl.cmd(`SDPD_CMD_PRE, 3'h0, 13'h0400, 1'b1);
	endtask
	task slow_test;
		pd_cycle(6'h29);
		chk(oas, 1'b1);
		#150;
		chk(oas, 1'b1);
		#50;
		chk(oas, 1'b0);
	endtask
	task fast_test;
		ctl.cmd(`SDPD_CMD_MRS, 3'h0, 13'h1000, 1'b1);
		#100;
		pd_cycle(6'h2c);
	endtask
	// reset pulled while powered down
	task reset_test;
		ctl.cmd(`SDPD_CMD_NOP, 3'h0, 13'h0, 1'b0);
		reset_n = 1'b0;
		#1;
		chk({pd, bon, oon, ook}, 4'h0);
		#99;
		reset_n = 1'b1;
		#10;
		chk({bon, dll, oon, ook}, 4'hf);
		chk(mr0, 13'h0);
		#50;
		ctl.cmd(`SDPD_CMD_NOP, 3'h0, 13'h0, 1'b1);
	endtask
	initial begin
		#86;
		reset_n = 1'b1;
		#60;
		ctl.cmd(`SDPD_CMD_NOP, 3'h0, 13'h0, 1'b1);
		wr_map_test;
		active_test;
		slow_test;
		fast_test;
		reset_test;
		conclude;
	end
endmodule

// file: sdpd_power_down_monitor.sv
`timescale 1ns/1ps
module sdpd_power_down_monitor (
	// clock and reset
	input wire        clock,
	input wire        reset_n,
	// command pins
	input wire        cke,
	input wire        cs_n,
	input wire        ras_n,
	input wire        cas_n,
	input wire        we_n,
	// state outputs
	input wire        powered_down,
	input wire        active_pd,
	input wire        precharge_pd,
	input wire        dll_on,
	input wire        buffers_on,
	input wire        odt_async,
	input wire [12:0] mr0
);
	wire idle = cs_n || {ras_n, cas_n, we_n} == 3'h7;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	entry_on_idle_a: assert property (buffers_on && !cke && idle |=> powered_down)
		else $error("missed entry");
	exit_on_idle_a: assert property (powered_down && cke && idle |=> !powered_down && buffers_on)
		else $error("missed exit");
	buffers_gated_a: assert property (powered_down |-> !buffers_on)
		else $error("buffers on while down");
	one_mode_a: assert property (powered_down |-> active_pd ^ precharge_pd)
		else $error("bad mode flags");
	dll_at_entry_a: assert property ($rose(powered_down) |-> dll_on == (active_pd || mr0[12]))
		else $error("bad dll at entry");
	dll_after_exit_a: assert property ($fell(powered_down) |-> dll_on)
		else $error("dll off after exit");
	odt_async_set_a: assert property ($rose(powered_down) |-> odt_async == (precharge_pd && !mr0[12]))
		else $error("bad odt mode");
	reset_quiet_a: assert property ($rose(reset_n) |-> !powered_down && !buffers_on)
		else $error("state after reset");
endmodule
bind sdpd_power_down sdpd_power_down_monitor u_mon (.clock(clock), .reset_n(reset_n),
	.cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
	.powered_down(powered_down), .active_pd(active_pd), .precharge_pd(precharge_pd),
	.dll_on(dll_on), .buffers_on(buffers_on), .odt_async(odt_async), .mr0(mr0));
